// ---- design/i2rt_target.sv ----
/*
  Serial bus target giving an external controller write and read access to
  a 256-byte register space, with high-speed filter selection.
  Assumes the register file sits outside: it takes write strobes and
  answers rd_data combinationally for rd_addr. SDA is open drain.
*/
// Operation
// - After START a matching 7-bit address with write bit is acknowledged on the ninth clock.
// - The 8-bit register pointer that follows a write address is acknowledged.
// - Each data byte is acknowledged and committed at the next SDA rising edge after the ack.
// - Further write bytes are acknowledged and committed to successive registers.
// - STOP returns the input filters to the low-speed setting; repeated START keeps it.
// - After a read address ack, eight bits of the selected register go out MSB first.
// - A controller ack after a read byte makes the next register's byte follow.
// - STOP leaves the register pointer unchanged.
// - The high-speed code 0000_1xxx after START is answered with a not-acknowledge.
// - The high-speed filter setting holds across repeated STARTs until STOP.
// - Every pointer value in the 8-bit space is acknowledged.
// - SCL is never held low by this block.
// - General call and foreign addresses are not acknowledged.
// - After reset the low-speed filter setting is selected.
`timescale 1ns/1ns
module i2rt_target #(
  parameter logic [6:0] TGT_ADDR = 7'h2A
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic hs_filter_sel,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output i2rt_pkg::i2rt_wr_t wr
);

  // ----------------------------------------------------------------
  // Link side: bit captured on the rising SCL edge
  // ----------------------------------------------------------------
  logic bit_link_r;

  // Held stable through SCL high; read only after the synchronised rise
  always_ff @(posedge scl_clk)
  begin
    bit_link_r <= sda_i;
  end

  // ----------------------------------------------------------------
  // Pin synchronisation and bus events
  // ----------------------------------------------------------------
  logic [1:0] lvl;
  logic [1:0] lvl_d_r;

  i2rt_sync #(.WIDTH(2), .INIT(2'h3)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({scl_clk, sda_i}),
    .level(lvl)
  );

  always_ff @(posedge clk)
  begin
    if (!resetn)
      lvl_d_r <= 2'h3;
    else
      lvl_d_r <= lvl;
  end

  wire scl_rise = lvl[1] & ~lvl_d_r[1];
  wire scl_fall = ~lvl[1] & lvl_d_r[1];
  wire sda_rise = lvl[0] & ~lvl_d_r[0];
  wire sda_fall = ~lvl[0] & lvl_d_r[0];
  wire start_ev = sda_fall & lvl[1] & lvl_d_r[1];
  wire stop_ev = sda_rise & lvl[1] & lvl_d_r[1];

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  i2rt_pkg::i2rt_state_t st_r;
  logic [3:0] cnt_r;
  logic ack_ph_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic oe_r;
  logic mack_r;
  logic hs_r;
  logic [7:0] ptr_r;
  logic pend_r;
  logic [7:0] pend_addr_r;
  logic [7:0] pend_data_r;
  i2rt_pkg::i2rt_wr_t wr_r;

  wire byte_done = scl_fall & ~ack_ph_r & (cnt_r == i2rt_pkg::BYTE_BITS);
  wire ack_end = scl_fall & ack_ph_r;
  wire addr_hit = (sh_r[7:1] == TGT_ADDR);
  wire hs_code = (sh_r[7:3] == i2rt_pkg::HS_CODE_TOP);
  wire is_gcall = (sh_r == i2rt_pkg::GEN_CALL);
  wire wr_done = byte_done & (st_r == i2rt_pkg::ST_WDATA);
  wire rd_done = byte_done & (st_r == i2rt_pkg::ST_RDATA);
  wire commit = pend_r & (sda_rise | wr_done);
  wire rd_load = ack_end & (st_r == i2rt_pkg::ST_RDATA) & mack_r;
  wire [7:0] ptr_inc = ptr_r + i2rt_pkg::PTR_STEP;
  wire [7:0] tx_shift = {tx_r[6:0], 1'b0};

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_r <= i2rt_pkg::ST_IDLE;
      cnt_r <= i2rt_pkg::CNT_ZERO;
      ack_ph_r <= 1'b0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      oe_r <= 1'b0;
      mack_r <= 1'b0;
      hs_r <= 1'b0;
      ptr_r <= i2rt_pkg::PTR_RESET;
    end
    else if (stop_ev)
    begin
      st_r <= i2rt_pkg::ST_IDLE;
      ack_ph_r <= 1'b0;
      oe_r <= 1'b0;
      hs_r <= 1'b0;
    end
    else if (start_ev)
    begin
      // Repeated START keeps hs_r and ptr_r
      st_r <= i2rt_pkg::ST_ADDR;
      cnt_r <= i2rt_pkg::CNT_ZERO;
      ack_ph_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (ack_ph_r)
      begin
        if (st_r == i2rt_pkg::ST_RDATA)
          mack_r <= ~bit_link_r;
      end
      else
      begin
        sh_r <= {sh_r[6:0], bit_link_r};
        cnt_r <= cnt_r + 4'h1;
      end
    end
    else if (byte_done)
    begin
      ack_ph_r <= 1'b1;
      oe_r <= 1'b0;
      unique case (st_r)
        i2rt_pkg::ST_ADDR:
        begin
          if (addr_hit && sh_r[0] == i2rt_pkg::RW_WRITE && !is_gcall)
          begin
            oe_r <= 1'b1;
            st_r <= i2rt_pkg::ST_PTR;
          end
          else if (addr_hit && sh_r[0] == i2rt_pkg::RW_READ)
          begin
            oe_r <= 1'b1;
            mack_r <= 1'b1;
            st_r <= i2rt_pkg::ST_RDATA;
          end
          else
          begin
            hs_r <= hs_r | hs_code;
            st_r <= i2rt_pkg::ST_SKIP;
          end
        end
        i2rt_pkg::ST_PTR:
        begin
          ptr_r <= sh_r;
          oe_r <= 1'b1;
          st_r <= i2rt_pkg::ST_WDATA;
        end
        i2rt_pkg::ST_WDATA:
        begin
          oe_r <= 1'b1;
          ptr_r <= ptr_inc;
        end
        i2rt_pkg::ST_RDATA:
        begin
          ptr_r <= ptr_inc;
        end
        i2rt_pkg::ST_IDLE, i2rt_pkg::ST_SKIP:
        begin
          st_r <= i2rt_pkg::ST_SKIP;
        end
      endcase
    end
    else if (ack_end)
    begin
      ack_ph_r <= 1'b0;
      cnt_r <= i2rt_pkg::CNT_ZERO;
      oe_r <= 1'b0;
      if (rd_load)
      begin
        tx_r <= rd_data;
        oe_r <= ~rd_data[7];
      end
      else if (st_r == i2rt_pkg::ST_RDATA)
        st_r <= i2rt_pkg::ST_SKIP;
    end
    else if (scl_fall && st_r == i2rt_pkg::ST_RDATA)
    begin
      tx_r <= tx_shift;
      oe_r <= ~tx_shift[7];
    end
  end

  // ----------------------------------------------------------------
  // Write commit on the SDA rise after the acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pend_r <= 1'b0;
      pend_addr_r <= 8'h00;
      pend_data_r <= 8'h00;
      wr_r <= '0;
    end
    else
    begin
      wr_r.valid <= commit;
      if (commit)
      begin
        wr_r.addr <= pend_addr_r;
        wr_r.data <= pend_data_r;
      end
      if (wr_done)
      begin
        pend_r <= 1'b1;
        pend_addr_r <= ptr_r;
        pend_data_r <= sh_r;
      end
      else if (commit)
        pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs; no SCL driver exists, the controller owns all timing
  // ----------------------------------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe = oe_r;
  assign hs_filter_sel = hs_r;
  assign rd_addr = ptr_r;
  assign wr = wr_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_write_addr_ack;
    byte_done && st_r == i2rt_pkg::ST_ADDR && addr_hit && !sh_r[0];
  endsequence
  sequence s_read_addr_ack;
    byte_done && st_r == i2rt_pkg::ST_ADDR && addr_hit && sh_r[0];
  endsequence
  sequence s_tx_shift;
    scl_fall && st_r == i2rt_pkg::ST_RDATA && !ack_ph_r && cnt_r != i2rt_pkg::BYTE_BITS;
  endsequence

  chk_addr_ack: assert property (s_write_addr_ack
    |=> sda_oe && st_r == i2rt_pkg::ST_PTR) else $error("address not acked");
  chk_read_ack: assert property (s_read_addr_ack
    |=> sda_oe && mack_r && st_r == i2rt_pkg::ST_RDATA) else $error("read address not acked");
  chk_ptr_ack: assert property (byte_done && st_r == i2rt_pkg::ST_PTR
    |=> sda_oe && rd_addr == $past(sh_r)) else $error("pointer not acked");
  chk_gcall_nack: assert property (byte_done && st_r == i2rt_pkg::ST_ADDR && is_gcall
    |=> !sda_oe && ack_ph_r) else $error("general call acked");
  chk_hs_nack: assert property (byte_done && st_r == i2rt_pkg::ST_ADDR && hs_code
    |=> !sda_oe && hs_filter_sel) else $error("high-speed code mishandled");
  chk_stop_filter: assert property (stop_ev
    |=> !hs_filter_sel && $stable(rd_addr)) else $error("stop effects wrong");
  chk_sr_keeps_hs: assert property (start_ev && hs_r |=> hs_filter_sel)
    else $error("filter lost on repeated start");
  chk_commit_edge: assert property (pend_r && sda_rise && !wr_done
    |=> wr.valid && wr.addr == $past(pend_addr_r) && wr.data == $past(pend_data_r))
    else $error("write not committed on sda rise");
  chk_ptr_step: assert property (wr_done || rd_done |=> rd_addr == $past(ptr_inc))
    else $error("pointer did not step");
  chk_read_msb: assert property (rd_load
    |=> sda_oe == !tx_r[7] && st_r == i2rt_pkg::ST_RDATA) else $error("read MSB wrong");
  chk_read_shift: assert property (s_tx_shift
    |=> sda_oe == !tx_r[7] && tx_r == ($past(tx_r) << 1)) else $error("read bit order wrong");
  chk_read_next: assert property (rd_load && !stop_ev && !start_ev
    |=> tx_r == $past(rd_data)) else $error("next read byte not loaded");

endmodule : i2rt_target

// ---- design/i2rt_pkg.sv ----
/*
  Shared constants and types for the serial register-access target.
  Assumes a byte-wide register space of 256 locations outside this block.
*/
package i2rt_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] GEN_CALL = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_PTR   = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_SKIP  = 6'h20
  } i2rt_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } i2rt_wr_t;

endpackage : i2rt_pkg

// ---- design/i2rt_sync.sv ----
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous inputs; output level changes only when stages two and three agree.
*/
`timescale 1ns/1ns
module i2rt_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] lvl_r;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          s1_r[g] <= INIT[g];
          s2_r[g] <= INIT[g];
          s3_r[g] <= INIT[g];
          lvl_r[g] <= INIT[g];
        end
        else
        begin
          s1_r[g] <= async_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g])
          begin
            lvl_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

  assign level = lvl_r;

endmodule : i2rt_sync

// ---- tb/i2rt_ctl_model.sv ----
/*
  Behavioural bus controller driving SCL and its own SDA level.
  Assumes a pull-up outside; sda_drv high means SDA released.
*/
`timescale 1ns/1ns
module i2rt_ctl_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // Bus phases, t is a third of the SCL period
  // ----------------------------------------------------------------
  int t = 360;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task start;
    if (scl === 1'b0)
    begin
      #t sda_drv = 1'b1;
      #t scl = 1'b1;
    end
    #t sda_drv = 1'b0;
    #t scl = 1'b0;
  endtask : start
  task stop;
    #t sda_drv = 1'b0;
    #t scl = 1'b1;
    #t sda_drv = 1'b1;
    #t;
  endtask : stop
  // Eight bits MSB first, then the ninth bit
  task xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx, output logic r9);
    logic [8:0] v;
    logic [8:0] r;
    v = {tx, b9};
    for (int i = 8; i >= 0; i--)
    begin
      #t sda_drv = v[i];
      #t scl = 1'b1;
      #(t / 2) r[i] = sda;
      #(t - t / 2) scl = 1'b0;
    end
    rx = r[8:1];
    r9 = r[0];
  endtask : xfer
endmodule : i2rt_ctl_model

// ---- tb/tb.sv ----
/*
  Self-checking bench for the serial register-access target.
  Assumes the controller model and a byte register file kept here.
*/
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // Environment
  // ----------------------------------------------------------------
  localparam logic [7:0] AW = 8'h54;
  localparam logic [7:0] AR = 8'h55;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_o;
  logic sda_oe;
  logic hs_filter_sel;
  logic [7:0] rd_addr;
  i2rt_pkg::i2rt_wr_t wr;
  logic [7:0] regs [256];
  logic [15:0] cq [$];
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  wire sda = sda_drv & (sda_oe ? sda_o : 1'b1);
  wire [7:0] rd_data = regs[rd_addr];
  initial
  begin
    forever #4 clk = ~clk;
  end
  i2rt_target dut (.clk(clk), .resetn(resetn), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .hs_filter_sel(hs_filter_sel), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr(wr));
  i2rt_ctl_model m (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  always @(negedge clk)
  begin
    cyc++;
    if (wr.valid === 1'b1)
    begin
      cq.push_back({wr.addr, wr.data});
      regs[wr.addr] <= wr.data;
    end
    if (cyc == 80000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : cmp8
  task cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : cmp1
  task snd(input logic [7:0] b, input logic e9);
    logic [7:0] rx;
    logic r9;
    m.xfer(b, 1'b1, rx, r9);
    cmp1(r9, e9);
  endtask : snd
  task rcv(input logic nak, input logic [7:0] exp);
    logic [7:0] rx;
    logic r9;
    m.xfer(8'hFF, nak, rx, r9);
    cmp8(rx, exp);
  endtask : rcv
  task settle;
    repeat (30) @(negedge clk);
  endtask : settle
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    cmp1(hs_filter_sel, 1'b0);
    cmp8(rd_addr, 8'h00);
    cmp1(sda_oe, 1'b0);
    cmp1(wr.valid, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task t_write;
    m.start();
    snd(AW, 1'b0);
    snd(8'hFE, 1'b0);
    snd(8'h11, 1'b0);
    snd(8'h22, 1'b0);
    snd(8'h33, 1'b0);
    m.stop();
    settle();
    cmp8(8'(cq.size()), 8'h03);
    for (int i = 0; i < 3; i++)
    begin
      cmp8(cq[i][15:8], 8'hFE + 8'(i));
      cmp8(cq[i][7:0], 8'h11 * 8'(i + 1));
    end
    cmp8(rd_addr, 8'h01);
    cq.delete();
    $display("test write done");
  endtask : t_write
  task t_read;
    m.start();
    snd(AW, 1'b0);
    snd(8'hFF, 1'b0);
    m.start();
    snd(AR, 1'b0);
    rcv(1'b0, 8'h22);
    rcv(1'b1, 8'h33);
    m.stop();
    m.start();
    snd(AR, 1'b0);
    rcv(1'b1, 8'hA4);
    m.stop();
    settle();
    cmp8(8'(cq.size()), 8'h00);
    $display("test read done");
  endtask : t_read
  task t_nack;
    m.start();
    snd(8'h56, 1'b1);
    snd(8'h10, 1'b1);
    m.stop();
    m.start();
    snd(8'h00, 1'b1);
    snd(8'h55, 1'b1);
    m.stop();
    settle();
    cmp8(8'(cq.size()), 8'h00);
    cmp8(rd_addr, 8'h02);
    $display("test nack done");
  endtask : t_nack
  task t_hs;
    m.start();
    snd(8'h0D, 1'b1);
    settle();
    cmp1(hs_filter_sel, 1'b1);
    m.t = 104;
    m.start();
    snd(AW, 1'b0);
    snd(8'h40, 1'b0);
    snd(8'h77, 1'b0);
    m.start();
    settle();
    cmp1(hs_filter_sel, 1'b1);
    m.stop();
    m.t = 360;
    settle();
    cmp1(hs_filter_sel, 1'b0);
    cmp8(8'(cq.size()), 8'h01);
    cmp8(cq[0][15:8], 8'h40);
    cmp8(cq[0][7:0], 8'h77);
    $display("test high speed done");
  endtask : t_hs
  task close_out;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    for (int i = 0; i < 256; i++)
      regs[i] = 8'(i) ^ 8'hA5;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    t_reset();
    repeat (8) @(negedge clk);
    t_write();
    t_read();
    t_nack();
    t_hs();
    close_out();
  end
endmodule : tb
